/* gtc_pkg.sv */
// Package with register offsets, field positions, reset values and timing counts for the gated counter.
package gtc_pkg;
	localparam logic [3:0] GTC_ADDR_LOW = 4'h0;
	localparam logic [3:0] GTC_ADDR_HIGH = 4'h1;
	localparam logic [3:0] GTC_ADDR_CTRL = 4'h2;
	localparam logic [3:0] GTC_ADDR_GATE = 4'h3;
	localparam logic [3:0] GTC_ADDR_STAT = 4'h4;
	localparam int GTC_CTRL_RUN = 0;
	localparam int GTC_CTRL_SYNCDIS = 2;
	localparam int GTC_CTRL_OSCEN = 3;
	localparam int GTC_CTRL_PS_LO = 4;
	localparam int GTC_CTRL_CS_LO = 6;
	localparam int GTC_GATE_SS_LO = 0;
	localparam int GTC_GATE_TM = 5;
	localparam int GTC_GATE_POL = 6;
	localparam int GTC_GATE_EN = 7;
	localparam int GTC_STAT_OVF = 0;
	localparam int GTC_STAT_OSCRDY = 1;
	localparam int GTC_STAT_GVAL = 2;
	localparam logic [7:0] GTC_CTRL_RESET = 8'h00;
	localparam logic [7:0] GTC_GATE_RESET = 8'h00;
	localparam logic [1:0] GTC_CS_INSTR = 2'h0;
	localparam logic [1:0] GTC_CS_SYS = 2'h1;
	localparam logic [1:0] GTC_CS_EXT = 2'h2;
	localparam logic [1:0] GTC_CS_LFOSC = 2'h3;
	localparam logic [1:0] GTC_GS_PIN = 2'h0;
	localparam logic [1:0] GTC_GS_WRAP = 2'h1;
	localparam logic [1:0] GTC_GS_CMP1 = 2'h2;
	localparam logic [1:0] GTC_GS_CMP2 = 2'h3;
	localparam logic [10:0] GTC_OSC_READY_CYCLES = 11'h400;
	localparam logic [1:0] GTC_INSTR_DIV_LAST = 2'h3;
	localparam logic [15:0] GTC_COUNT_MAX = 16'hFFFF;
endpackage : gtc_pkg

/* gtc_sync.sv */
// Three-stage synchroniser with agreement filter for one pin input.
module gtc_sync
(
	input wire logic clk,
	input wire logic rst,
	input wire logic pin,
	output logic level
);
	logic meta;
	logic s2;
	logic s3;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			level <= 1'b0;
		end
		else
		begin
			meta <= pin;
			s2 <= meta;
			s3 <= s2;
			if (s2 == s3)
			begin
				level <= s3;
			end
		end
	end
endmodule : gtc_sync

/* gtc_timer.sv */
// Gated 16-bit timer and counter with prescaler, clock select, gate and secondary oscillator ready status.
// How it works
// - Sixteen-bit counter, byte writes load it directly.
// - Run off stops; gate enable restricts counting.
// - Clock select picks instruction, system, external, oscillator.
// - Internal source counts through prescaler as timer.
// - System clock advances four counts per instruction.
// - External pin counts rising edges, always synchronised.
// - Falling edge needed before first counted rise.
// - Prescaler divides 1/2/4/8, cleared by byte writes.
// - Oscillator enable clears ready; 1024 cycles set it.
// - Byte reads always return a valid value.
// - Gate polarity chooses active level for counting.
// - Gate source selects pin, wrap, comparator one, two.
// - Companion timer wrap pulses the gate logic.
// - Toggle mode flips gate on each gate source rise.
// - Toggle flip-flop held clear while toggle off.
// - Prescale codes 00,01,10,11 divide 1,2,4,8.
// - Run off clears the gate flip-flop.
// - Rollover FFFF to 0000 sets overflow flag.
module gtc_timer
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic ext_clock_pin,
	input wire logic crystal_in_pin,
	input wire logic low_freq_internal_osc,
	input wire logic gate_pin,
	input wire logic companion_timer_wrap_pulse,
	input wire logic comparator_one_out,
	input wire logic comparator_two_out,
	input wire logic ovf_clear,
	output logic overflow_flag,
	output logic secondary_osc_ready
);
	import gtc_pkg::*;

	typedef enum logic [1:0] {GTC_ARM_IDLE = 2'b00, GTC_ARM_WAIT_LOW = 2'b01, GTC_ARM_READY = 2'b11} gtc_arm_t;

	logic [7:0] ctrl;
	logic [7:0] gate_cfg;
	logic [15:0] count;
	logic [2:0] prescale;
	logic [1:0] instr_div;
	logic gate_ff;
	logic gate_prev;
	logic ext_prev;
	logic osc_prev;
	logic lf_prev;
	logic [10:0] osc_cnt;
	gtc_arm_t arm;
	gtc_arm_t next_arm;

	logic ext_sync;
	logic osc_sync;
	logic lf_sync;
	logic gpin_sync;

	gtc_sync u_sync_ext (.clk(clk), .rst(rst), .pin(ext_clock_pin), .level(ext_sync));
	gtc_sync u_sync_osc (.clk(clk), .rst(rst), .pin(crystal_in_pin), .level(osc_sync));
	gtc_sync u_sync_lf (.clk(clk), .rst(rst), .pin(low_freq_internal_osc), .level(lf_sync));
	gtc_sync u_sync_gate (.clk(clk), .rst(rst), .pin(gate_pin), .level(gpin_sync));

	wire run_bit = ctrl[GTC_CTRL_RUN];
	wire secondary_osc_enable = ctrl[GTC_CTRL_OSCEN];
	wire [1:0] prescale_select = ctrl[GTC_CTRL_PS_LO +: 2];
	wire [1:0] clock_select = ctrl[GTC_CTRL_CS_LO +: 2];
	wire [1:0] gate_source_select = gate_cfg[GTC_GATE_SS_LO +: 2];
	wire gate_toggle_enable = gate_cfg[GTC_GATE_TM];
	wire gate_polarity = gate_cfg[GTC_GATE_POL];
	wire gate_enable_bit = gate_cfg[GTC_GATE_EN];

	wire wr_low = wr && (addr == GTC_ADDR_LOW);
	wire wr_high = wr && (addr == GTC_ADDR_HIGH);
	wire wr_count = wr_low || wr_high;
	wire wr_ctrl = wr && (addr == GTC_ADDR_CTRL);
	wire wr_gate = wr && (addr == GTC_ADDR_GATE);
	wire osc_en_rise = wr_ctrl && wdata[GTC_CTRL_OSCEN] && !secondary_osc_enable;

	// Rising edges of every source after the synchronisers; in unsynchronised mode the
	// pin still crosses the same filter here, since this block has a single clock domain.
	wire ext_rise = ext_sync && !ext_prev;
	wire ext_fall = !ext_sync && ext_prev;
	wire osc_rise = osc_sync && !osc_prev;
	wire lf_rise = lf_sync && !lf_prev;
	wire instr_tick = (instr_div == GTC_INSTR_DIV_LAST);
	wire use_pin = (clock_select == GTC_CS_EXT) && !secondary_osc_enable;

	// Counter mode needs a falling edge before the first counted rise.
	wire pin_rise_ok = ext_rise && (arm == GTC_ARM_READY);

	logic src_tick;
	always_comb
	begin
		case (clock_select)
			GTC_CS_INSTR: src_tick = instr_tick;
			GTC_CS_SYS: src_tick = 1'b1;
			GTC_CS_EXT: src_tick = secondary_osc_enable ? osc_rise : pin_rise_ok;
			GTC_CS_LFOSC: src_tick = lf_rise;
			default: src_tick = 1'b0;
		endcase
	end

	logic gate_src;
	always_comb
	begin
		case (gate_source_select)
			GTC_GS_PIN: gate_src = gpin_sync;
			GTC_GS_WRAP: gate_src = companion_timer_wrap_pulse;
			GTC_GS_CMP1: gate_src = comparator_one_out;
			GTC_GS_CMP2: gate_src = comparator_two_out;
			default: gate_src = 1'b0;
		endcase
	end

	wire gate_src_rise = gate_src && !gate_prev;
	wire gate_value = gate_toggle_enable ? gate_ff : gate_src;
	wire gate_active = (gate_value == gate_polarity);
	wire count_enable = run_bit && (!gate_enable_bit || gate_active);

	logic [2:0] ps_mask;
	always_comb
	begin
		case (prescale_select)
			2'h0: ps_mask = 3'h0;
			2'h1: ps_mask = 3'h1;
			2'h2: ps_mask = 3'h3;
			2'h3: ps_mask = 3'h7;
			default: ps_mask = 3'h0;
		endcase
	end

	wire ps_tick = src_tick && count_enable;
	wire ps_out = ps_tick && ((prescale & ps_mask) == ps_mask);
	wire [15:0] next_count = count + 16'h0001;
	wire wrap = ps_out && !wr_count && (count == GTC_COUNT_MAX);

	always_comb
	begin
		next_arm = arm;
		case (arm)
			GTC_ARM_IDLE: if (run_bit && use_pin) next_arm = GTC_ARM_WAIT_LOW;
			GTC_ARM_WAIT_LOW: if (ext_fall) next_arm = GTC_ARM_READY;
			GTC_ARM_READY: if (!run_bit || !use_pin) next_arm = GTC_ARM_IDLE;
			default: next_arm = GTC_ARM_IDLE;
		endcase
		if (wr_count)
		begin
			next_arm = GTC_ARM_WAIT_LOW;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ext_prev <= 1'b0;
			osc_prev <= 1'b0;
			lf_prev <= 1'b0;
			gate_prev <= 1'b0;
			instr_div <= 2'h0;
			arm <= GTC_ARM_IDLE;
		end
		else
		begin
			ext_prev <= ext_sync;
			osc_prev <= osc_sync;
			lf_prev <= lf_sync;
			gate_prev <= gate_src;
			instr_div <= instr_div + 2'h1;
			arm <= next_arm;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl <= GTC_CTRL_RESET;
			gate_cfg <= GTC_GATE_RESET;
		end
		else
		begin
			if (wr_ctrl)
			begin
				ctrl <= {wdata[7:2], 1'b0, wdata[0]};
			end
			if (wr_gate)
			begin
				gate_cfg <= {wdata[7:5], 3'h0, wdata[1:0]};
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			count <= 16'h0000;
			prescale <= 3'h0;
		end
		else if (wr_count)
		begin
			prescale <= 3'h0;
			if (wr_low)
			begin
				count[7:0] <= wdata;
			end
			else
			begin
				count[15:8] <= wdata;
			end
		end
		else if (ps_tick)
		begin
			prescale <= ps_out ? 3'h0 : prescale + 3'h1;
			if (ps_out)
			begin
				count <= next_count;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			gate_ff <= 1'b0;
		end
		else if (!run_bit || !gate_toggle_enable)
		begin
			gate_ff <= 1'b0;
		end
		else if (gate_src_rise)
		begin
			gate_ff <= !gate_ff;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			overflow_flag <= 1'b0;
		end
		else if (wrap)
		begin
			overflow_flag <= 1'b1;
		end
		else if (ovf_clear)
		begin
			overflow_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			osc_cnt <= 11'h000;
			secondary_osc_ready <= 1'b0;
		end
		else if (osc_en_rise || !secondary_osc_enable)
		begin
			osc_cnt <= 11'h000;
			secondary_osc_ready <= 1'b0;
		end
		else if (osc_rise && !secondary_osc_ready)
		begin
			osc_cnt <= osc_cnt + 11'h001;
			if (osc_cnt + 11'h001 == GTC_OSC_READY_CYCLES)
			begin
				secondary_osc_ready <= 1'b1;
			end
		end
	end

	// Whole-byte snapshot of a single-clock counter, so every byte read is coherent.
	logic [7:0] next_rdata;
	always_comb
	begin
		case (addr)
			GTC_ADDR_LOW: next_rdata = count[7:0];
			GTC_ADDR_HIGH: next_rdata = count[15:8];
			GTC_ADDR_CTRL: next_rdata = ctrl;
			GTC_ADDR_GATE: next_rdata = {gate_cfg[7:3], gate_value, gate_cfg[1:0]};
			GTC_ADDR_STAT: next_rdata = {5'h00, gate_value, secondary_osc_ready, overflow_flag};
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rdata <= 8'h00;
		end
		else
		begin
			rdata <= rd ? next_rdata : 8'h00;
		end
	end

	property p_run_off_holds;
		@(posedge clk) disable iff (rst)
		(!run_bit && !wr_count) |=> (count == $past(count));
	endproperty
	a_run_off_holds: assert property (p_run_off_holds) else $error("Counter moved while stopped.");

	property p_gate_blocks;
		@(posedge clk) disable iff (rst)
		(gate_enable_bit && !gate_active && !wr_count) |=> (count == $past(count));
	endproperty
	a_gate_blocks: assert property (p_gate_blocks) else $error("Counter moved with gate inactive.");

	property p_sys_four;
		@(posedge clk) disable iff (rst)
		(clock_select == GTC_CS_SYS && prescale_select == 2'h0 && run_bit && !gate_enable_bit && !wr_count)
			[*4] |=> (count == $past(count, 4) + 16'h0004);
	endproperty
	a_sys_four: assert property (p_sys_four) else $error("System clock did not give four counts.");

	property p_write_clears_ps;
		@(posedge clk) disable iff (rst)
		wr_count |=> (prescale == 3'h0);
	endproperty
	a_write_clears_ps: assert property (p_write_clears_ps) else $error("Prescaler not cleared by write.");

	property p_wrap_flag;
		@(posedge clk) disable iff (rst)
		wrap |=> (overflow_flag && count == 16'h0000);
	endproperty
	a_wrap_flag: assert property (p_wrap_flag) else $error("Rollover did not set flag.");

	property p_toggle_clear;
		@(posedge clk) disable iff (rst)
		(!gate_toggle_enable || !run_bit) |=> !gate_ff;
	endproperty
	a_toggle_clear: assert property (p_toggle_clear) else $error("Toggle flip-flop not held clear.");

	property p_osc_clear;
		@(posedge clk) disable iff (rst)
		osc_en_rise |=> !secondary_osc_ready;
	endproperty
	a_osc_clear: assert property (p_osc_clear) else $error("Oscillator ready not cleared.");

	property p_write_low;
		@(posedge clk) disable iff (rst)
		wr_low |=> (count[7:0] == $past(wdata));
	endproperty
	a_write_low: assert property (p_write_low) else $error("Low byte write lost.");

	property p_armed_after_write;
		@(posedge clk) disable iff (rst)
		wr_count |=> (arm != GTC_ARM_READY);
	endproperty
	a_armed_after_write: assert property (p_armed_after_write) else $error("Count armed without falling edge.");
endmodule : gtc_timer

/* gtc_far_model.sv */
// Far-side model of the external clock pin, crystal and low-frequency oscillator.
module gtc_far_model
(
	input wire logic clk,
	output logic ext_clock_pin,
	output logic crystal_in_pin,
	output logic low_freq_internal_osc
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		ext_clock_pin = 1'b0;
		crystal_in_pin = 1'b0;
		low_freq_internal_osc = 1'b0;
	end
	task automatic set(input int w, input logic v);
		case (w)
			0: ext_clock_pin <= v;
			1: crystal_in_pin <= v;
			default: low_freq_internal_osc <= v;
		endcase
	endtask : set
	// Each cycle falls then rises and the source stands still high afterwards.
	task automatic pulse(input int w, input int n, input int half);
		@(posedge clk);
		repeat (n)
		begin
			set(w, 1'b0);
			repeat (half) @(posedge clk);
			set(w, 1'b1);
			repeat (half) @(posedge clk);
		end
	endtask : pulse
endmodule : gtc_far_model

/* gated_timer16_counter_tb.sv */
// Self-checking bench for the gated sixteen-bit counter.
module gated_timer16_counter_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import gtc_pkg::*;
	logic clk, rst, wr, rd, gate_pin, wrap, cmp1, cmp2, ovf_clear, ovf, rdy, ext, xtal, lfo;
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	logic [15:0] v;
	int bad_count = 0;
	int tests_run = 0;
	gtc_far_model far_u (.clk(clk), .ext_clock_pin(ext), .crystal_in_pin(xtal), .low_freq_internal_osc(lfo));
	gtc_timer dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.ext_clock_pin(ext), .crystal_in_pin(xtal), .low_freq_internal_osc(lfo), .gate_pin(gate_pin),
		.companion_timer_wrap_pulse(wrap), .comparator_one_out(cmp1), .comparator_two_out(cmp2),
		.ovf_clear(ovf_clear), .overflow_flag(ovf), .secondary_osc_ready(rdy));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g, input int tol);
		tests_run++;
		if ((^g === 1'bx) || (int'(g) > int'(e) + tol) || (int'(g) + tol < int'(e)))
		begin
			bad_count++;
			$display("wrong value %s expected %0h seen %0h", n, e, g);
		end
	endtask : chk
	// Loads zero while stopped, runs for n cycles, stops and reads both bytes.
	task automatic run(input logic [7:0] c, input int n, output logic [15:0] r);
		wr_reg(GTC_ADDR_LOW, 8'h00);
		wr_reg(GTC_ADDR_HIGH, 8'h00);
		wr_reg(GTC_ADDR_CTRL, c);
		repeat (n) @(posedge clk);
		wr_reg(GTC_ADDR_CTRL, 8'h00);
		rd_reg(GTC_ADDR_LOW, r[7:0]);
		rd_reg(GTC_ADDR_HIGH, r[15:8]);
	endtask : run
	task automatic final_report;
		$display("compares %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	initial
	begin
		repeat (100000) @(posedge clk);
		bad_count++;
		final_report();
	end
	initial
	begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		{cmp2, cmp1, wrap, gate_pin, ovf_clear} = 5'h00;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 8; a++)
		begin
			rd_reg(a[3:0], v[7:0]);
			chk("reset", 16'h0000, {8'h00, v[7:0]}, 0);
		end
		wr_reg(GTC_ADDR_CTRL, 8'hFE);
		rd_reg(GTC_ADDR_CTRL, v[7:0]);
		chk("ctrl", 16'h00FC, {8'h00, v[7:0]}, 0);
		wr_reg(GTC_ADDR_LOW, 8'h34);
		wr_reg(GTC_ADDR_HIGH, 8'h12);
		rd_reg(GTC_ADDR_LOW, v[7:0]);
		rd_reg(GTC_ADDR_HIGH, v[15:8]);
		chk("load", 16'h1234, v, 0);
		$display("test registers done");
		for (int p = 0; p < 4; p++)
		begin
			run({GTC_CS_SYS, p[1:0], 4'h1}, 64, v);
			chk("sys", 16'(64 >> p), v, 2);
		end
		run({GTC_CS_INSTR, 6'h01}, 64, v);
		chk("instr", 16'h0010, v, 2);
		wr_reg(GTC_ADDR_GATE, 8'h80);
		run({GTC_CS_SYS, 6'h00}, 64, v);
		chk("off", 16'h0000, v, 0);
		$display("test sources done");
		for (int s = 0; s < 4; s++)
		begin
			@(posedge clk);
			{cmp2, cmp1, wrap, gate_pin} <= ~(4'h1 << s);
			wr_reg(GTC_ADDR_GATE, {4'hC, 2'b00, s[1:0]});
			run({GTC_CS_SYS, 6'h01}, 32, v);
			chk("gate_hold", 16'h0000, v, 1);
			wr_reg(GTC_ADDR_GATE, {4'h8, 2'b00, s[1:0]});
			run({GTC_CS_SYS, 6'h01}, 32, v);
			chk("gate_open", 16'h0020, v, 2);
		end
		@(posedge clk);
		{cmp2, cmp1, wrap, gate_pin} <= 4'h0;
		wr_reg(GTC_ADDR_GATE, 8'hC0);
		wr_reg(GTC_ADDR_GATE, 8'hE0);
		run({GTC_CS_SYS, 6'h01}, 32, v);
		chk("toggle_clear", 16'h0000, v, 1);
		fork
			run({GTC_CS_SYS, 6'h01}, 64, v);
			begin
				repeat (12) @(posedge clk);
				gate_pin <= 1'b1;
				repeat (4) @(posedge clk);
				gate_pin <= 1'b0;
			end
		join
		chk("toggle_set", 16'd54, v, 6);
		wr_reg(GTC_ADDR_GATE, 8'h00);
		$display("test gate done");
		wr_reg(GTC_ADDR_LOW, 8'hFD);
		wr_reg(GTC_ADDR_HIGH, 8'hFF);
		wr_reg(GTC_ADDR_CTRL, {GTC_CS_SYS, 6'h01});
		repeat (6) @(posedge clk);
		wr_reg(GTC_ADDR_CTRL, 8'h00);
		chk("ovf", 16'h0001, {15'h0, ovf}, 0);
		rd_reg(GTC_ADDR_LOW, v[7:0]);
		rd_reg(GTC_ADDR_HIGH, v[15:8]);
		chk("wrap", 16'h0005, v, 2);
		@(posedge clk);
		ovf_clear <= 1'b1;
		@(posedge clk);
		ovf_clear <= 1'b0;
		@(posedge clk);
		#1;
		chk("ovf_clear", 16'h0000, {15'h0, ovf}, 0);
		$display("test overflow done");
		far_u.pulse(0, 1, 4);
		fork
			run(8'h81, 80, v);
			begin
				repeat (10) @(posedge clk);
				far_u.pulse(0, 5, 4);
			end
		join
		chk("ext", 16'h0005, v, 0);
		fork
			run(8'h85, 80, v);
			begin
				repeat (10) @(posedge clk);
				far_u.pulse(0, 3, 4);
			end
		join
		chk("ext_nosync", 16'h0003, v, 1);
		fork
			run({GTC_CS_LFOSC, 6'h01}, 80, v);
			begin
				repeat (10) @(posedge clk);
				far_u.pulse(2, 6, 4);
			end
		join
		chk("lfosc", 16'h0006, v, 1);
		// Pin already low when the count is loaded: the first rise must not count.
		@(posedge clk);
		far_u.set(0, 1'b0);
		repeat (8) @(posedge clk);
		fork
			run(8'h81, 80, v);
			begin
				repeat (10) @(posedge clk);
				far_u.pulse(0, 3, 4);
			end
		join
		chk("ext_arm", 16'h0002, v, 0);
		$display("test external done");
		wr_reg(GTC_ADDR_CTRL, 8'h08);
		far_u.pulse(1, 1000, 2);
		chk("osc_early", 16'h0000, {15'h0, rdy}, 0);
		far_u.pulse(1, 40, 2);
		chk("osc_ready", 16'h0001, {15'h0, rdy}, 0);
		wr_reg(GTC_ADDR_CTRL, 8'h00);
		wr_reg(GTC_ADDR_CTRL, 8'h08);
		#1;
		chk("osc_restart", 16'h0000, {15'h0, rdy}, 0);
		$display("test oscillator done");
		final_report();
	end
endmodule : gated_timer16_counter_tb
